/* common/ucp_regs.svh */
`ifndef UCP_REGS_SVH
`define UCP_REGS_SVH
// ----------------------------------------------------------------------
// character codes
// ----------------------------------------------------------------------
`define UCP_CH_DOLLAR 8'h24
`define UCP_CH_HASH 8'h23
`define UCP_CH_COMMA 8'h2c
`define UCP_CH_CR 8'h0d
`define UCP_CH_SP 8'h20
`define UCP_CH_HT 8'h09
`define UCP_CH_ZERO 8'h30
`define UCP_CH_NINE 8'h39
`define UCP_CH_DOT 8'h2e
`define UCP_CH_PLUS 8'h2b
`define UCP_CH_MINUS 8'h2d
`define UCP_CH_EXP 8'h65
`define UCP_CH_AXIS0 8'h78
`define UCP_CH_AXIS2 8'h7a
// ----------------------------------------------------------------------
// checksum and limits
// ----------------------------------------------------------------------
`define UCP_CRC_SEED 8'hff
`define UCP_CRC_POLY 8'h07
`define UCP_CRC_MAX 12'h0ff
`define UCP_DEC_TEN 12'h00a
`define UCP_MAX_BODY 7'h63
`define UCP_NAME_MAX 4'hb
`define UCP_ACK_NAME 88'h5554494c4954594d4f4445
`define UCP_PARAMS_NONE 7'h1
`define UCP_PARAMS_ONE 7'h2
`define UCP_PARAMS_TWO 7'h3
// ----------------------------------------------------------------------
// command names, packed right aligned, with their lengths
// ----------------------------------------------------------------------
`define UCP_NM_IAX 32'h00696178
`define UCP_NM_ERRCLR 32'h00006965
`define UCP_NM_ISV 32'h00697376
`define UCP_NM_SAVE 32'h73617665
`define UCP_NM_EXIT 32'h0000786e
`define UCP_NM_SBTO 32'h7362746f
`define UCP_LEN_2 4'h2
`define UCP_LEN_3 4'h3
`define UCP_LEN_4 4'h4
// ----------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------
`define UCP_ST_OK 4'h0
`define UCP_ST_INVALID 4'h1
`define UCP_ST_CRC 4'h2
`define UCP_ST_UNKNOWN 4'h3
`define UCP_ST_COUNT 4'h4
`define UCP_ST_PARAM 4'h5
`define UCP_ST_SAVES 4'h6
`define UCP_ST_SAVEERR 4'h7
`define UCP_ST_CLIPPED 4'h8
`endif

/* common/ucp_pkg.sv */
package ucp_pkg;
  typedef enum logic [3:0] {
    UCP_TX_IDLE, UCP_TX_HASH, UCP_TX_NAME, UCP_TX_C1, UCP_TX_STAT,
    UCP_TX_C2, UCP_TX_VAL, UCP_TX_C3, UCP_TX_CRC, UCP_TX_CR
  } ucp_tx_t;
  typedef enum logic [2:0] {
    UCP_CMD_NONE, UCP_CMD_IAX, UCP_CMD_ERRCLR, UCP_CMD_ISV, UCP_CMD_SAVE,
    UCP_CMD_EXIT, UCP_CMD_SBTO
  } ucp_cmd_t;
endpackage : ucp_pkg

/* design/ucp_ascii_parser.sv */
`timescale 1ns/1ns
`include "ucp_regs.svh"
// Overview of operation
// RULE_01: entering mode sends name, checksum, carriage return
// RULE_02: all text ASCII, numbers in decimal
// RULE_03: host starts commands with dollar sign
// RULE_04: host uses lower case letters only
// RULE_05: fields separated by commas both ways
// RULE_06: leading spaces and tabs before parameters skipped
// RULE_07: numbers may use period and exponent
// RULE_08: host ends command with 8-bit checksum
// RULE_09: host ends with CR, at most 100 characters
// RULE_10: response starts with hash then command name
// RULE_11: second response field is status, zero ok
// RULE_12: response ends with checksum then CR
// RULE_13: CRC-8 polynomial 0x07, seed all ones
// RULE_14: checksum covers start char through last comma
// RULE_15: checksum sent as decimal 0 to 255
// RULE_16: status 1 missing start or unconfigured axis
// RULE_17: status 2 on checksum mismatch
// RULE_18: status 3 unknown name; no echo for 1-3
// RULE_19: status 4 bad count, 5 bad value
// RULE_20: status 6 saves exhausted, 7 save failed
// RULE_21: status 8 when bias change was clipped
// RULE_22: lowest applicable status code is reported
// RULE_23: changes hit working settings; save writes flash
// RULE_24: error query returns then clears accumulator
// RULE_25: exit command returns to normal mode
// RULE_26: save still writes flash, reports zero left
// RULE_27: decode on CR, exactly one response each
module ucp_ascii_parser (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] rxChar,
  input wire logic rxValid,
  input wire logic txReady,
  input wire logic enterUtil,
  input wire logic [2:0] axisConfigured,
  input wire logic [15:0] saveRemaining,
  input wire logic saveFail,
  input wire logic biasClipped,
  input wire logic [7:0] errAccum,
  output logic [7:0] txChar,
  output logic txValid,
  output logic utilMode,
  output logic flashWrite,
  output logic settingsUpdate,
  output logic errClear,
  output logic exitNormal,
  output logic [1:0] biasAxis
);
  import ucp_pkg::*;

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  function automatic logic [7:0] crc8Step(input logic [7:0] crc,
                                          input logic [7:0] ch);
    logic [7:0] c;
    c = crc ^ ch;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ({c[6:0], 1'b0} ^ `UCP_CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction : crc8Step

  function automatic logic [19:0] toBcd(input logic [15:0] v);
    logic [19:0] b;
    b = '0;
    for (int i = 15; i >= 0; i--)
    begin
      for (int d = 0; d < 5; d++)
        if (b[4*d +: 4] > 4'h4)
          b[4*d +: 4] = b[4*d +: 4] + 4'h3;
      b = {b[18:0], v[i]};
    end
    return b;
  endfunction : toBcd

  function automatic logic [3:0] topDigit(input logic [19:0] b);
    logic [3:0] t;
    t = '0;
    for (int d = 1; d < 5; d++)
      if (b[4*d +: 4] != 4'h0)
        t = 4'(d);
    return t;
  endfunction : topDigit

  function automatic logic isDigit(input logic [7:0] ch);
    return ch >= `UCP_CH_ZERO && ch <= `UCP_CH_NINE;
  endfunction : isDigit

  // --------------------------------------------------------------------
  // receive side parsing
  // --------------------------------------------------------------------
  ucp_tx_t txState;
  logic firstSeen, dollarOk, tooLong, fieldStarted, curBad, paramBad;
  logic lastOk, exitPend, respEcho, respHasVal, ackOnly;
  logic [6:0] fieldIdx, charCount;
  logic [87:0] nameReg;
  logic [3:0] nameLen, respStatus;
  logic [7:0] crcRun, crcAtComma, lastVal, axisChar, txCrc;
  logic [15:0] respVal;
  logic [19:0] digBuf;
  // wide enough to walk the eleven characters of the entry name
  logic [3:0] digIdx;
  logic [11:0] accum;
  logic rxAccept, crAccept, enterAccept, canSend, txLast;
  logic isWs, isNum, crcOk, axisOk, axisCfg, countOk;
  ucp_cmd_t cmd;
  logic [3:0] nextStatus;
  logic [7:0] cur;
  logic [1:0] axisIdx;

  // the parser holds off while a response is still going out
  assign rxAccept = rxValid && utilMode && txState == UCP_TX_IDLE;
  assign crAccept = rxAccept && rxChar == `UCP_CH_CR; // RULE_27
  assign enterAccept = enterUtil && !utilMode && txState == UCP_TX_IDLE;
  assign isWs = rxChar == `UCP_CH_SP || rxChar == `UCP_CH_HT;
  assign isNum = isDigit(rxChar) || rxChar == `UCP_CH_DOT ||
    rxChar == `UCP_CH_EXP || rxChar == `UCP_CH_PLUS ||
    rxChar == `UCP_CH_MINUS; // RULE_07
  assign accum = 12'(lastVal) * `UCP_DEC_TEN +
    {4'h0, rxChar - `UCP_CH_ZERO};

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      firstSeen <= 1'b0;
      dollarOk <= 1'b0;
      tooLong <= 1'b0;
      charCount <= '0;
      crcRun <= `UCP_CRC_SEED;
      crcAtComma <= `UCP_CRC_SEED;
      fieldIdx <= '0;
      fieldStarted <= 1'b0;
      curBad <= 1'b0;
      paramBad <= 1'b0;
      lastVal <= '0;
      lastOk <= 1'b0;
      axisChar <= '0;
    end
    else if (crAccept)
    begin
      firstSeen <= 1'b0;
      // a bare terminator must not inherit the last start check
      dollarOk <= 1'b0; // RULE_16
      tooLong <= 1'b0;
      charCount <= '0;
      crcRun <= `UCP_CRC_SEED; // RULE_13
      fieldIdx <= '0;
      fieldStarted <= 1'b0;
      curBad <= 1'b0;
      paramBad <= 1'b0;
      lastOk <= 1'b0;
    end
    else if (rxAccept)
    begin
      charCount <= charCount + 7'h1;
      if (charCount >= `UCP_MAX_BODY)
        tooLong <= 1'b1;
      crcRun <= crc8Step(crcRun, rxChar); // RULE_14
      if (!firstSeen)
      begin
        firstSeen <= 1'b1;
        dollarOk <= rxChar == `UCP_CH_DOLLAR; // RULE_03
      end
      else if (rxChar == `UCP_CH_COMMA) // RULE_05
      begin
        fieldIdx <= fieldIdx + 7'h1;
        crcAtComma <= crc8Step(crcRun, rxChar); // RULE_14
        paramBad <= paramBad || curBad;
        curBad <= 1'b0;
        fieldStarted <= 1'b0;
        lastVal <= '0;
        lastOk <= 1'b1;
      end
      else if (fieldIdx != 7'h0 && !(isWs && !fieldStarted)) // RULE_06
      begin
        fieldStarted <= 1'b1;
        if (fieldIdx == `UCP_PARAMS_ONE && !fieldStarted)
          axisChar <= rxChar;
        if (fieldIdx == `UCP_PARAMS_NONE && !isNum)
          curBad <= 1'b1; // RULE_19
        if (!isDigit(rxChar) || accum > `UCP_CRC_MAX)
          lastOk <= 1'b0; // RULE_15
        else
          lastVal <= accum[7:0];
      end
    end
  end

  // the name register keeps the last name for the echo
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nameReg <= '0;
      nameLen <= '0;
    end
    else if (enterAccept)
    begin
      nameReg <= `UCP_ACK_NAME; // RULE_01
      nameLen <= `UCP_NAME_MAX;
    end
    else if (rxAccept && !crAccept && !firstSeen)
    begin
      nameReg <= '0;
      nameLen <= '0;
    end
    else if (rxAccept && !crAccept && fieldIdx == 7'h0 &&
             rxChar != `UCP_CH_COMMA && nameLen < `UCP_NAME_MAX)
    begin
      nameReg <= {nameReg[79:0], rxChar};
      nameLen <= nameLen + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // decode, taken only on the terminator
  // --------------------------------------------------------------------
  always_comb
  begin
    cmd = UCP_CMD_NONE;
    if (nameLen == `UCP_LEN_3 && nameReg[31:0] == `UCP_NM_IAX)
      cmd = UCP_CMD_IAX;
    if (nameLen == `UCP_LEN_2 && nameReg[31:0] == `UCP_NM_ERRCLR)
      cmd = UCP_CMD_ERRCLR;
    if (nameLen == `UCP_LEN_3 && nameReg[31:0] == `UCP_NM_ISV)
      cmd = UCP_CMD_ISV;
    if (nameLen == `UCP_LEN_4 && nameReg[31:0] == `UCP_NM_SAVE)
      cmd = UCP_CMD_SAVE;
    if (nameLen == `UCP_LEN_2 && nameReg[31:0] == `UCP_NM_EXIT)
      cmd = UCP_CMD_EXIT;
    if (nameLen == `UCP_LEN_4 && nameReg[31:0] == `UCP_NM_SBTO)
      cmd = UCP_CMD_SBTO;
  end

  assign crcOk = fieldIdx != 7'h0 && fieldStarted && lastOk &&
    lastVal == crcAtComma; // RULE_17
  assign axisIdx = 2'(axisChar - `UCP_CH_AXIS0);
  assign axisOk = axisChar >= `UCP_CH_AXIS0 && axisChar <= `UCP_CH_AXIS2;
  assign axisCfg = cmd == UCP_CMD_SBTO && fieldIdx == `UCP_PARAMS_TWO &&
    axisOk && !axisConfigured[axisIdx];
  assign countOk = cmd == UCP_CMD_SBTO ?
    (fieldIdx == `UCP_PARAMS_ONE || fieldIdx == `UCP_PARAMS_TWO) :
    fieldIdx == `UCP_PARAMS_NONE;

  // ascending test order leaves the lowest code standing
  always_comb
  begin
    if (!dollarOk || tooLong || axisCfg) // RULE_16
      nextStatus = `UCP_ST_INVALID;
    else if (!crcOk) // RULE_17
      nextStatus = `UCP_ST_CRC;
    else if (cmd == UCP_CMD_NONE) // RULE_18
      nextStatus = `UCP_ST_UNKNOWN;
    else if (!countOk) // RULE_19
      nextStatus = `UCP_ST_COUNT;
    else if (paramBad || (fieldIdx == `UCP_PARAMS_TWO && !axisOk))
      nextStatus = `UCP_ST_PARAM; // RULE_19
    else if (cmd == UCP_CMD_SAVE && saveRemaining == 16'h0000)
      nextStatus = `UCP_ST_SAVES; // RULE_20
    else if (cmd == UCP_CMD_SAVE && saveFail)
      nextStatus = `UCP_ST_SAVEERR; // RULE_20
    else if (cmd == UCP_CMD_SBTO && biasClipped)
      nextStatus = `UCP_ST_CLIPPED; // RULE_21
    else
      nextStatus = `UCP_ST_OK; // RULE_22
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      respStatus <= `UCP_ST_OK;
      respEcho <= 1'b0;
      respHasVal <= 1'b0;
      respVal <= '0;
      ackOnly <= 1'b0;
    end
    else if (enterAccept)
    begin
      respEcho <= 1'b1;
      ackOnly <= 1'b1;
    end
    else if (crAccept)
    begin
      ackOnly <= 1'b0;
      respStatus <= nextStatus; // RULE_11
      respEcho <= nextStatus == `UCP_ST_OK ||
        nextStatus >= `UCP_ST_COUNT; // RULE_18
      respHasVal <= (nextStatus == `UCP_ST_OK ||
        nextStatus >= `UCP_ST_SAVES) && (cmd == UCP_CMD_IAX ||
        cmd == UCP_CMD_ERRCLR || cmd == UCP_CMD_ISV || cmd == UCP_CMD_SAVE);
      if (cmd == UCP_CMD_ERRCLR)
        respVal <= {8'h00, errAccum}; // RULE_24
      else if (cmd == UCP_CMD_IAX)
        respVal <= {13'h0000, axisConfigured};
      else if (nextStatus == `UCP_ST_SAVES)
        respVal <= '0; // RULE_26
      else
        respVal <= saveRemaining;
    end
  end

  // --------------------------------------------------------------------
  // side effects of an executed command
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flashWrite <= 1'b0;
      settingsUpdate <= 1'b0;
      errClear <= 1'b0;
      biasAxis <= '0;
    end
    else
    begin
      // flash is written only here, even past the save limit
      flashWrite <= crAccept && cmd == UCP_CMD_SAVE &&
        (nextStatus == `UCP_ST_OK || nextStatus == `UCP_ST_SAVES ||
        nextStatus == `UCP_ST_SAVEERR); // RULE_23 RULE_26
      settingsUpdate <= crAccept && cmd == UCP_CMD_SBTO &&
        (nextStatus == `UCP_ST_OK ||
        nextStatus == `UCP_ST_CLIPPED); // RULE_23
      errClear <= crAccept && cmd == UCP_CMD_ERRCLR &&
        nextStatus == `UCP_ST_OK; // RULE_24
      if (crAccept && cmd == UCP_CMD_SBTO)
        biasAxis <= axisIdx;
    end
  end

  assign txLast = txState == UCP_TX_CR && canSend;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      utilMode <= 1'b0;
      exitPend <= 1'b0;
      exitNormal <= 1'b0;
    end
    else
    begin
      exitNormal <= txLast && exitPend; // RULE_25
      if (enterAccept)
        utilMode <= 1'b1;
      else if (txLast && exitPend)
        utilMode <= 1'b0; // RULE_25
      if (crAccept)
        exitPend <= cmd == UCP_CMD_EXIT && nextStatus == `UCP_ST_OK;
      else if (txLast)
        exitPend <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // response transmitter
  // --------------------------------------------------------------------
  assign canSend = !txValid || txReady;

  always_comb
  begin
    unique case (txState)
      UCP_TX_HASH: cur = `UCP_CH_HASH; // RULE_10
      UCP_TX_NAME: cur = nameReg[8*(nameLen - 4'h1 - digIdx) +: 8];
      UCP_TX_STAT: cur = `UCP_CH_ZERO + {4'h0, respStatus}; // RULE_02
      UCP_TX_VAL, UCP_TX_CRC:
        cur = `UCP_CH_ZERO + {4'h0, digBuf[4*digIdx +: 4]}; // RULE_15
      UCP_TX_CR: cur = `UCP_CH_CR; // RULE_12
      UCP_TX_IDLE: cur = `UCP_CH_CR;
      default: cur = `UCP_CH_COMMA; // RULE_05
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txState <= UCP_TX_IDLE;
      txChar <= '0;
      txValid <= 1'b0;
      txCrc <= `UCP_CRC_SEED;
      digBuf <= '0;
      digIdx <= '0;
    end
    else if (txState == UCP_TX_IDLE)
    begin
      if (canSend)
        txValid <= 1'b0;
      if (crAccept || enterAccept) // RULE_27
      begin
        txState <= UCP_TX_HASH;
        txCrc <= `UCP_CRC_SEED; // RULE_13
        digIdx <= '0;
      end
    end
    else if (canSend)
    begin
      txChar <= cur;
      txValid <= 1'b1;
      txCrc <= crc8Step(txCrc, cur); // RULE_14
      unique case (txState)
        UCP_TX_HASH:
          txState <= (respEcho && nameLen != 4'h0) ? UCP_TX_NAME :
            (ackOnly ? UCP_TX_C3 : UCP_TX_C1);
        UCP_TX_NAME:
          if (digIdx == nameLen - 4'h1)
          begin
            digIdx <= '0;
            txState <= ackOnly ? UCP_TX_C3 : UCP_TX_C1; // RULE_01
          end
          else
            digIdx <= digIdx + 4'h1;
        UCP_TX_C1: txState <= UCP_TX_STAT;
        UCP_TX_STAT: txState <= respHasVal ? UCP_TX_C2 : UCP_TX_C3;
        UCP_TX_C2:
        begin
          digBuf <= toBcd(respVal);
          digIdx <= topDigit(toBcd(respVal));
          txState <= UCP_TX_VAL;
        end
        UCP_TX_C3:
        begin
          digBuf <= toBcd({8'h00, crc8Step(txCrc, cur)}); // RULE_15
          digIdx <= topDigit(toBcd({8'h00, crc8Step(txCrc, cur)}));
          txState <= UCP_TX_CRC;
        end
        UCP_TX_VAL, UCP_TX_CRC:
          if (digIdx == 4'h0)
            txState <= txState == UCP_TX_VAL ? UCP_TX_C3 : UCP_TX_CR;
          else
            digIdx <= digIdx - 4'h1;
        UCP_TX_CR: txState <= UCP_TX_IDLE; // RULE_12
        default: txState <= UCP_TX_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_ack_req;
    enterAccept && !txValid;
  endsequence
  property p_ack_hash;
    s_ack_req |-> ##2 (txValid && txChar == `UCP_CH_HASH);
  endproperty
  a_ack_hash: assert property (p_ack_hash) // RULE_01
    else $error("ack did not open with hash");

  property p_status_char;
    (txState == UCP_TX_STAT && canSend) |=>
      (txChar == `UCP_CH_ZERO + {4'h0, respStatus});
  endproperty
  a_status_char: assert property (p_status_char) // RULE_11
    else $error("status character wrong");

  property p_no_start;
    (crAccept && !dollarOk) |=> (respStatus == `UCP_ST_INVALID && !respEcho);
  endproperty
  a_no_start: assert property (p_no_start) // RULE_16
    else $error("missing start not status 1");

  property p_bad_crc;
    (crAccept && dollarOk && !tooLong && !axisCfg && !crcOk) |=>
      respStatus == `UCP_ST_CRC;
  endproperty
  a_bad_crc: assert property (p_bad_crc) // RULE_17
    else $error("checksum mismatch not status 2");

  property p_save_limit;
    (crAccept && nextStatus == `UCP_ST_SAVES) |=>
      (flashWrite && respVal == 16'h0000);
  endproperty
  a_save_limit: assert property (p_save_limit) // RULE_26
    else $error("save limit did not still write");

  property p_err_clear;
    (crAccept && cmd == UCP_CMD_ERRCLR && nextStatus == `UCP_ST_OK) |=>
      errClear ##1 !errClear;
  endproperty
  a_err_clear: assert property (p_err_clear) // RULE_24
    else $error("error accumulator clear not one pulse");

  sequence s_exit_last;
    exitPend && txLast;
  endsequence
  property p_exit;
    s_exit_last |=> (exitNormal && !utilMode);
  endproperty
  a_exit: assert property (p_exit) // RULE_25
    else $error("exit did not leave mode");

  property p_one_resp;
    crAccept |=> txState == UCP_TX_HASH;
  endproperty
  a_one_resp: assert property (p_one_resp) // RULE_27
    else $error("terminator did not start a response");

  property p_ends_cr;
    txLast |=> (txValid && txChar == `UCP_CH_CR && txState == UCP_TX_IDLE);
  endproperty
  a_ends_cr: assert property (p_ends_cr) // RULE_12
    else $error("response not ended by CR");

endmodule : ucp_ascii_parser

/* sim/ucp_host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// host side: sends command bytes, collects response bytes
// ----------------------------------------------------------------------
module ucp_host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] txChar,
  input wire logic txValid,
  output logic [7:0] rxChar,
  output logic rxValid,
  output logic txReady
);
  logic [255:0] resp;
  int nResp;
  int stall;
  int cyc;

  initial
  begin
    rxChar = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b0;
    resp = '0;
    nResp = 0;
    stall = 0;
    cyc = 0;
  end

  // slow mode takes one char in three, so txChar must hold while refused
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    txReady <= rst_b && (stall == 0 || cyc % 3 == 0);
    if (txValid && txReady)
    begin
      resp <= {resp[247:0], txChar};
      if (txChar == 8'h0d)
        nResp <= nResp + 1;
    end
  end

  // one char per clock, back to back; idle line shows the inverted char
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge sys_clk);
      rxChar <= s[i];
      rxValid <= 1'b1;
    end
    @(posedge sys_clk);
    rxChar <= ~rxChar;
    rxValid <= 1'b0;
  endtask : send
endmodule : ucp_host_model

/* sim/testbench.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((e) !== (g)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench;
  logic sys_clk, rst_b, rxValid, txReady, enterUtil, saveFail;
  logic biasClipped, txValid, utilMode, flashWrite, settingsUpdate;
  logic errClear, exitNormal;
  logic [7:0] rxChar, errAccum, txChar;
  logic [2:0] axisConfigured;
  logic [15:0] saveRemaining;
  logic [1:0] biasAxis;
  int n_mismatch, cmp_count, nFlash, nUpd, nClr, nExit;

  ucp_ascii_parser i_ucp_ascii_parser (.sys_clk(sys_clk), .rst_b(rst_b),
    .rxChar(rxChar), .rxValid(rxValid), .txReady(txReady),
    .enterUtil(enterUtil), .axisConfigured(axisConfigured),
    .saveRemaining(saveRemaining), .saveFail(saveFail),
    .biasClipped(biasClipped), .errAccum(errAccum), .txChar(txChar),
    .txValid(txValid), .utilMode(utilMode), .flashWrite(flashWrite),
    .settingsUpdate(settingsUpdate), .errClear(errClear),
    .exitNormal(exitNormal), .biasAxis(biasAxis));
  ucp_host_model i_ucp_host_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .txChar(txChar), .txValid(txValid), .rxChar(rxChar),
    .rxValid(rxValid), .txReady(txReady));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    nFlash <= nFlash + (flashWrite === 1'b1);
    nUpd <= nUpd + (settingsUpdate === 1'b1);
    nClr <= nClr + (errClear === 1'b1);
    nExit <= nExit + (exitNormal === 1'b1);
  end

  function automatic logic [7:0] crc8(input string s);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < s.len(); i++)
    begin
      c = c ^ s[i];
      for (int b = 0; b < 8; b++)
        c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  // appends decimal checksum and terminator
  function automatic string wc(input string s);
    return {s, $sformatf("%0d", crc8(s)), "\r"};
  endfunction : wc

  function automatic logic [255:0] pack(input string s);
    logic [255:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++)
      v = {v[247:0], s[i]};
    return v;
  endfunction : pack

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // host waits for the terminator before sending again
  task automatic xfer(input string c, input string e, input string nm);
    int n0;
    int k;
    n0 = i_ucp_host_model.nResp;
    i_ucp_host_model.resp = '0;
    i_ucp_host_model.send(c);
    k = 0;
    while (i_ucp_host_model.nResp == n0 && k < 3000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
    repeat (2) @(posedge sys_clk);
    `CHK(nm, pack(e), i_ucp_host_model.resp)
    `CHK("count", n0 + 1, i_ucp_host_model.nResp)
  endtask : xfer

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_ack();
    string a;
    a = {"#", $sformatf("%s", 88'h5554494c4954594d4f4445), ",234\r"};
    `CHK("txValid", 1'b0, txValid)
    @(posedge sys_clk);
    enterUtil <= 1'b1;
    @(posedge sys_clk);
    enterUtil <= 1'b0;
    i_ucp_host_model.resp = '0;
    repeat (40) @(posedge sys_clk);
    `CHK("ack", pack(a), i_ucp_host_model.resp)
    `CHK("mode", 1'b1, utilMode)
    $display("test ack done");
  endtask : t_ack

  task automatic t_query();
    int n0;
    n0 = nClr;
    xfer(wc("$iax,"), wc("#iax,0,5,"), "iax");
    i_ucp_host_model.stall = 1;
    xfer(wc({"$", "ie,"}), wc("#ie,0,200,"), "ie");
    i_ucp_host_model.stall = 0;
    `CHK("clear", n0 + 1, nClr)
    $display("test query done");
  endtask : t_query

  task automatic t_errors();
    string c[7];
    string e[7];
    c = '{wc("iax,"), "$iax,0\r", wc("$dbto,"), wc("$iax,7,"),
          wc("$sbto,1x,"), "$dbto,0\r", "\r"};
    e = '{"#,1,", "#,2,", "#,3,", "#iax,4,", "#sbto,5,", "#,2,", "#,1,"};
    c[1] = {"$iax,", $sformatf("%0d", 8'(crc8("$iax,") + 8'h01)), "\r"};
    c[5] = {"$dbto,", $sformatf("%0d", 8'(crc8("$dbto,") + 8'h01)), "\r"};
    for (int i = 0; i < 7; i++)
      xfer(c[i], wc(e[i]), "status");
    $display("test errors done");
  endtask : t_errors

  task automatic t_bias();
    int n0;
    n0 = nUpd;
    @(posedge sys_clk);
    axisConfigured <= 3'h7;
    xfer(wc("$sbto, \t1.5e-3,"), wc("#sbto,0,"), "sbto");
    xfer(wc("$sbto,-0.25,\ty,"), wc("#sbto,0,"), "axis");
    `CHK("upd", n0 + 2, nUpd)
    `CHK("axis", 2'h1, biasAxis)
    axisConfigured <= 3'h5;
    xfer(wc("$sbto,0.5,y,"), wc("#,1,"), "noaxis");
    axisConfigured <= 3'h7;
    biasClipped <= 1'b1;
    xfer(wc("$sbto,2.0,"), wc("#sbto,8,"), "clip");
    biasClipped <= 1'b0;
    $display("test bias done");
  endtask : t_bias

  task automatic t_save();
    int n0;
    logic [15:0] rem[4];
    string st[4];
    rem = '{16'h2290, 16'h0000, 16'h2290, 16'h0000};
    st = '{"0,8848,", "6,0,", "7,8848,", "6,0,"};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      saveRemaining <= rem[i];
      saveFail <= i[1];
      n0 = nFlash;
      xfer(wc("$save,"), wc({"#save,", st[i]}), "save");
      `CHK("flash", n0 + 1, nFlash)
    end
    saveRemaining <= 16'h2290;
    xfer(wc("$isv,"), wc("#isv,0,8848,"), "isv");
    $display("test save done");
  endtask : t_save

  task automatic t_exit();
    int n0;
    n0 = nExit;
    xfer(wc({"$", "xn,"}), wc("#xn,0,"), "exit");
    `CHK("exitp", n0 + 1, nExit)
    `CHK("mode", 1'b0, utilMode)
    n0 = i_ucp_host_model.nResp;
    i_ucp_host_model.send(wc("$iax,"));
    repeat (100) @(posedge sys_clk);
    `CHK("dropped", n0, i_ucp_host_model.nResp)
    $display("test exit done");
  endtask : t_exit

  initial
  begin
    rst_b = 1'b0;
    enterUtil = 1'b0;
    axisConfigured = 3'h5;
    saveRemaining = 16'h0000;
    saveFail = 1'b0;
    biasClipped = 1'b0;
    errAccum = 8'hc8;
    n_mismatch = 0;
    cmp_count = 0;
    nFlash = 0;
    nUpd = 0;
    nClr = 0;
    nExit = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    t_ack();
    t_query();
    t_errors();
    t_bias();
    t_save();
    t_exit();
    end_of_test();
  end
endmodule : testbench
